// ---- bench/spc_far_model.sv ----
// far-side serial model: listens to the block as controller, plays controller to it
`timescale 1ns/1ps
module spc_far_model (
	// sampling clock and observed pins
	input wire logic aclk,
	input wire logic sck_o,
	input wire logic sdo,
	input wire logic samp_rise,
	// pins driven toward the block
	output logic sck_pin,
	output logic sdi,
	output logic sel_n,
	// last byte seen on the block's data output
	output logic [7:0] got_byte
);
	logic sck_q;
	initial begin
		sck_pin = 1'b0;
		sdi = 1'b1;
		sel_n = 1'b1;
		got_byte = 8'h00;
	end
	// ----------------
	// capture
	// ----------------
	// takes data after the sampling edge, so a change on the wrong edge shifts the byte
	// sample on the other edge
	always @(posedge aclk) begin
		sck_q <= sck_o;
		if (sck_q !== sck_o && sck_o === samp_rise)
			got_byte <= {got_byte[6:0], sdo};
	end
	// one frame, msb first; each bit spans both clock edges so either sampling edge works
	// select and data drive
	task automatic frame(input logic [7:0] b, input logic pol, input logic sel);
		sel_n = ~sel;
		sck_pin = pol;
		#80;
		for (int i = 7; i >= 0; i--) begin
			sdi = b[i];
			#40 sck_pin = ~pol;
			#80 sck_pin = pol;
			#40;
		end
		// released line: no pull, so show the inverse rather than a stale bit
		sdi = ~b[0];
		#80 sel_n = 1'b1;
	endtask
endmodule

// ---- bench/tb.sv ----
// testbench: register access, controller and target transfers
`timescale 1ns/1ps
module tb;
	import spc_pkg::*;
	logic aclk, aresetn;
	logic [7:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic sck_o, sck_oe, sck_wire, sdo, sck_pin, sdi, sel_n, port_owned, samp_rise;
	logic pol, edg, frm;
	logic [7:0] got_byte;
	logic [7:0] pat [5] = '{8'hB4, 8'h2D, 8'h71, 8'hE8, 8'h4B};
	int bad_count, check_count;

	// shared clock pin level, chosen by the block's clock drive enable alone
	assign sck_wire = sck_oe ? sck_o : sck_pin;

	spc_top dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sck_i(sck_wire), .sck_o(sck_o), .sck_oe(sck_oe), .sdi(sdi), .sdo(sdo),
		.target_select_pin_n(sel_n), .select_pin_port_owned(port_owned));
	spc_far_model far (.aclk(aclk), .sck_o(sck_o), .sdo(sdo), .samp_rise(samp_rise),
		.sck_pin(sck_pin), .sdi(sdi), .sel_n(sel_n), .got_byte(got_byte));

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	// ----------------
	// tasks
	// ----------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// both write channels offered together, each dropped when taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		bready <= 1'b0;
		rs = bresp;
	endtask
	task automatic axr(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		rready <= 1'b0;
		rd = rdata;
		rs = rresp;
	endtask
	// poll status; the read that sees done also clears it
	task automatic wait_done();
		int i;
		for (i = 0; i < 300; i++) begin
			axr(SPC_STAT_OFF);
			if (rd[SPC_DONE_BIT] === 1'b1)
				break;
		end
		chk(i < 300, 32'h1);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// hang guard at 200 us, more than ten times the length of the run
	initial begin
		#200000;
		bad_count++;
		wrap_up();
	end
	// ----------------
	// main sequence
	// ----------------
	initial begin
		{aresetn, awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
		wdata = '0;
		wstrb = '0;
		samp_rise = 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(port_owned, 1'b1);
		chk(sck_oe, 1'b0);
		axr(SPC_CTRL_OFF);
		chk(rd, 32'h0);
		axr(8'h0C);
		chk(rs, SPC_RESP_SLVERR);
		axw(8'h0C, 32'hFFFF);
		chk(rs, SPC_RESP_SLVERR);
		// controller in every polarity and edge, last one framed with edge select set
		for (int k = 0; k < 5; k++) begin
			pol = k[0];
			edg = k[1] | (k == 4);
			frm = (k == 4);
			// framed ignores edge select, select enable kept clear
			samp_rise <= pol ^ (edg & ~frm);
			axw(SPC_CTRL_OFF, 32'h21 | {pol, 6'h0} | {edg, 8'h0} | {frm, 4'h0});
			repeat (2) @(posedge aclk);
			chk(sck_oe, 1'b1);
			chk(sck_o, pol);
			axw(SPC_DATA_OFF, {24'h0, pat[k]});
			wait_done();
			chk(got_byte, pat[k]);
			axr(SPC_DATA_OFF);
			chk(rd, 32'hFF);
			chk(sck_o, pol);
		end
		// target role with sample phase cleared, select pin in use
		axw(SPC_CTRL_OFF, 32'h81);
		repeat (2) @(posedge aclk);
		chk(sck_oe, 1'b0);
		chk(port_owned, 1'b0);
		axw(SPC_DATA_OFF, 32'hA5);
		far.frame(8'h6C, 1'b0, 1'b1);
		wait_done();
		axr(SPC_DATA_OFF);
		chk(rd, 32'h6C);
		// armed but deselected: stays busy with no done
		axw(SPC_DATA_OFF, 32'h5A);
		far.frame(8'h93, 1'b0, 1'b0);
		repeat (10) @(posedge aclk);
		axr(SPC_STAT_OFF);
		chk(rd[1:0], 32'h1);
		axw(SPC_CTRL_OFF, 32'h01);
		repeat (2) @(posedge aclk);
		chk(port_owned, 1'b1);
		far.frame(8'h93, 1'b0, 1'b0);
		wait_done();
		axr(SPC_DATA_OFF);
		chk(rd, 32'h93);
		wrap_up();
	end
endmodule

// ---- hw/spc_pkg.sv ----
// package for the serial port phase and role configuration block
// ---------------------------------------------------------------
// ---------------------------------------------------------------
package spc_pkg;
	// register byte offsets
	localparam logic [7:0] SPC_CTRL_OFF = 8'h00;
	localparam logic [7:0] SPC_DATA_OFF = 8'h04;
	localparam logic [7:0] SPC_STAT_OFF = 8'h08;
	// control field positions
	localparam int SPC_SAMPLE_BIT = 9;
	localparam int SPC_EDGE_BIT = 8;
	localparam int SPC_SSEL_BIT = 7;
	localparam int SPC_POL_BIT = 6;
	localparam int SPC_ROLE_BIT = 5;
	localparam int SPC_FRAME_BIT = 4;
	localparam int SPC_EN_BIT = 0;
	// status field positions
	localparam int SPC_BUSY_BIT = 0;
	localparam int SPC_DONE_BIT = 1;
	// reset values
	localparam logic [9:0] SPC_CTRL_RST = 10'h000;
	localparam logic [7:0] SPC_DATA_RST = 8'h00;
	// controller clock half period in aclk cycles
	localparam int SPC_HALF_DIV = 4;
	// axi responses
	localparam logic [1:0] SPC_RESP_OKAY = 2'h0;
	localparam logic [1:0] SPC_RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {SPC_IDLE, SPC_SHIFT, SPC_END} spc_state_t;
endpackage

// ---- hw/spc_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module spc_sync #(
	parameter int W = 3
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// async in, synced out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s1_next;
	logic [W-1:0] q_next;

	// first stage only feeds second
	always_comb begin
		s1_next = d;
		q_next = s1_reg;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_reg <= '0;
			q <= '0;
		end else begin
			s1_reg <= s1_next;
			q <= q_next;
		end
	end
endmodule

// ---- hw/spc_top.sv ----
// phase, polarity, role and select configuration with a small shifter
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module spc_top
	import spc_pkg::*;
#(
	parameter int HALF_DIV = SPC_HALF_DIV
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// serial clock pin
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe,
	// serial data pins
	input wire logic sdi,
	output logic sdo,
	// target select pin, active low
	input wire logic target_select_pin_n,
	// select pin released to port control
	output logic select_pin_port_owned
);
	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [9:0] ctrl_reg, ctrl_next;
	logic [7:0] tx_reg, tx_next, rx_reg, rx_next, sh_reg, sh_next;
	logic done_reg, done_next;
	logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
	logic [7:0] awa_reg, awa_next;
	logic [31:0] wd_reg, wd_next;
	logic [3:0] ws_reg, ws_next;
	logic bvalid_next, rvalid_next, awready_next, wready_next, arready_next;
	logic [1:0] bresp_next, rresp_next;
	logic [31:0] rdata_next;
	spc_state_t st_reg, st_next;
	logic [2:0] cnt_reg, cnt_next;
	logic [7:0] div_reg, div_next;
	logic phase_reg, phase_next;
	logic sck_reg, sck_next, sdo_reg, sdo_next, sck_oe_next, port_next;
	logic sck_d_reg;
	logic start_wr;

	// configuration fields
	logic sample_end, edge_sel, ssel_en, pol, role, framed, en;
	assign sample_end = ctrl_reg[SPC_SAMPLE_BIT];
	assign edge_sel = ctrl_reg[SPC_EDGE_BIT];
	assign ssel_en = ctrl_reg[SPC_SSEL_BIT];
	assign pol = ctrl_reg[SPC_POL_BIT];
	assign role = ctrl_reg[SPC_ROLE_BIT];
	assign framed = ctrl_reg[SPC_FRAME_BIT];
	assign en = ctrl_reg[SPC_EN_BIT];

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [2:0] pins_s;
	spc_sync #(.W(3)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({sck_i, sdi, target_select_pin_n}),
		.q(pins_s)
	);
	logic sck_s, sdi_s, sel_n_s;
	assign sck_s = pins_s[2];
	assign sdi_s = pins_s[1];
	assign sel_n_s = pins_s[0];

	// ---------------------------------------------------------------
	// axi4-lite slave
	// ---------------------------------------------------------------
	logic aw_have, w_have, do_wr;
	logic [7:0] wa;
	logic [31:0] wdv;
	logic [3:0] wsv;
	assign aw_have = aw_hold_reg | (s_axi_awvalid & s_axi_awready);
	assign w_have = w_hold_reg | (s_axi_wvalid & s_axi_wready);
	assign do_wr = aw_have & w_have & ~s_axi_bvalid;
	assign wa = aw_hold_reg ? awa_reg : s_axi_awaddr;
	assign wdv = w_hold_reg ? wd_reg : s_axi_wdata;
	assign wsv = w_hold_reg ? ws_reg : s_axi_wstrb;

	// write path; channels taken in either order, response after both
	always_comb begin
		aw_hold_next = aw_hold_reg;
		w_hold_next = w_hold_reg;
		awa_next = awa_reg;
		wd_next = wd_reg;
		ws_next = ws_reg;
		bvalid_next = s_axi_bvalid;
		bresp_next = s_axi_bresp;
		ctrl_next = ctrl_reg;
		tx_next = tx_reg;
		start_wr = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_next = 1'b1;
			awa_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_next = 1'b1;
			wd_next = s_axi_wdata;
			ws_next = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (do_wr) begin
			aw_hold_next = 1'b0;
			w_hold_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = SPC_RESP_OKAY;
			case (wa)
				SPC_CTRL_OFF: begin
					if (wsv[0]) ctrl_next[7:0] = wdv[7:0];
					if (wsv[1]) ctrl_next[9:8] = wdv[9:8];
				end
				SPC_DATA_OFF: begin
					if (wsv[0]) begin
						tx_next = wdv[7:0];
						start_wr = 1'b1;
					end
				end
				SPC_STAT_OFF: ;
				default: bresp_next = SPC_RESP_SLVERR;
			endcase
		end
		awready_next = ~aw_hold_next & ~bvalid_next;
		wready_next = ~w_hold_next & ~bvalid_next;
	end

	// read path; one read at a time
	always_comb begin
		rvalid_next = s_axi_rvalid;
		rdata_next = s_axi_rdata;
		rresp_next = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rresp_next = SPC_RESP_OKAY;
			case (s_axi_araddr)
				SPC_CTRL_OFF: rdata_next = {22'h0, ctrl_reg};
				SPC_DATA_OFF: rdata_next = {24'h000000, rx_reg};
				SPC_STAT_OFF: rdata_next = {30'h0, done_reg, st_reg != SPC_IDLE};
				default: begin
					rdata_next = 32'h00000000;
					rresp_next = SPC_RESP_SLVERR;
				end
			endcase
		end
		arready_next = ~rvalid_next;
	end

	// ---------------------------------------------------------------
	// shift engine
	// ---------------------------------------------------------------
	logic tick, lead, trail, sck_rise, sck_fall, lead_t, trail_t, sel_ok, clr_done;
	// divider gives one-cycle enable per controller half period
	assign tick = (div_reg == 8'(HALF_DIV - 1));
	assign sck_rise = sck_s & ~sck_d_reg;
	assign sck_fall = ~sck_s & sck_d_reg;
	// target edges: leading is idle-to-active, trailing the reverse
	assign lead_t = pol ? sck_fall : sck_rise;
	assign trail_t = pol ? sck_rise : sck_fall;
	assign sel_ok = ~ssel_en | framed | ~sel_n_s;
	assign clr_done = s_axi_arvalid & s_axi_arready & (s_axi_araddr == SPC_STAT_OFF);
	// framed mode forces edge select off
	logic edge_eff;
	assign edge_eff = edge_sel & ~framed;

	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		div_next = tick ? 8'h00 : div_reg + 8'h01;
		phase_next = phase_reg;
		sh_next = sh_reg;
		rx_next = rx_reg;
		sdo_next = sdo_reg;
		sck_next = sck_reg;
		done_next = done_reg;
		lead = 1'b0;
		trail = 1'b0;
		// done set wins over read clear
		if (clr_done) done_next = 1'b0;
		if (role) begin
			lead = tick & (st_reg == SPC_SHIFT) & ~phase_reg;
			trail = tick & (st_reg == SPC_SHIFT) & phase_reg;
		end else begin
			lead = lead_t & sel_ok;
			trail = trail_t & sel_ok;
		end
		case (st_reg)
			SPC_IDLE: begin
				// controller clock parked at idle level
				sck_next = pol;
				if (start_wr && en) begin
					st_next = SPC_SHIFT;
					cnt_next = 3'h0;
					phase_next = 1'b0;
					sh_next = tx_next;
					div_next = 8'h00;
					// edge 1: first bit must be out before leading edge
					if (edge_eff) sdo_next = tx_next[7];
				end
			end
			SPC_SHIFT: begin
				if (role && tick) begin
					phase_next = ~phase_reg;
					sck_next = phase_reg ? pol : ~pol;
				end
				// shift on the edge opposite the output change; late sampling uses trailing, in controller role only
				if ((role && sample_end) ? trail : (edge_eff ? lead : trail)) begin
					sh_next = {sh_reg[6:0], sdi_s};
					cnt_next = cnt_reg + 3'h1;
					if (cnt_reg == 3'h7) st_next = SPC_END;
				end
				// edge 1: output changes on active-to-idle transition
				if (edge_eff && trail) sdo_next = sh_next[7];
				// edge 0: output changes on idle-to-active transition
				if (!edge_eff && lead) sdo_next = sh_next[7];
			end
			SPC_END: begin
				rx_next = sh_reg;
				done_next = 1'b1;
				st_next = SPC_IDLE;
				sck_next = pol;
			end
			default: st_next = SPC_IDLE;
		endcase
		// only the controller drives the clock pin
		sck_oe_next = role & en;
		// pin returned to port when select unused
		port_next = ~ssel_en | role;
	end

	// ---------------------------------------------------------------
	// state registers
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= SPC_CTRL_RST;
			tx_reg <= SPC_DATA_RST;
			rx_reg <= SPC_DATA_RST;
			sh_reg <= SPC_DATA_RST;
			done_reg <= 1'b0;
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awa_reg <= 8'h00;
			wd_reg <= 32'h00000000;
			ws_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
			st_reg <= SPC_IDLE;
			cnt_reg <= 3'h0;
			div_reg <= 8'h00;
			phase_reg <= 1'b0;
			sck_reg <= 1'b0;
			sck_d_reg <= 1'b0;
			sdo_reg <= 1'b0;
			sck_oe <= 1'b0;
			select_pin_port_owned <= 1'b1;
		end else begin
			ctrl_reg <= ctrl_next;
			tx_reg <= tx_next;
			rx_reg <= rx_next;
			sh_reg <= sh_next;
			done_reg <= done_next;
			aw_hold_reg <= aw_hold_next;
			w_hold_reg <= w_hold_next;
			awa_reg <= awa_next;
			wd_reg <= wd_next;
			ws_reg <= ws_next;
			s_axi_awready <= awready_next;
			s_axi_wready <= wready_next;
			s_axi_bvalid <= bvalid_next;
			s_axi_bresp <= bresp_next;
			s_axi_arready <= arready_next;
			s_axi_rvalid <= rvalid_next;
			s_axi_rdata <= rdata_next;
			s_axi_rresp <= rresp_next;
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			div_reg <= div_next;
			phase_reg <= phase_next;
			sck_reg <= sck_next;
			sck_d_reg <= sck_s;
			sdo_reg <= sdo_next;
			sck_oe <= sck_oe_next;
			select_pin_port_owned <= port_next;
		end
	end
	assign sck_o = sck_reg;
	assign sdo = sdo_reg;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_idle_clk;
		@(posedge aclk) disable iff (!aresetn)
		(st_reg == SPC_IDLE && $past(st_reg) == SPC_IDLE) |-> (sck_o == $past(pol));
	endproperty
	a_idle_clk: assert property (p_idle_clk) else $error("clock not at idle level");

	property p_pol_idle;
		@(posedge aclk) disable iff (!aresetn)
		(st_reg == SPC_IDLE) |=> (sck_o == $past(pol));
	endproperty
	a_pol_idle: assert property (p_pol_idle) else $error("polarity idle wrong");

	property p_role_oe;
		@(posedge aclk) disable iff (!aresetn)
		##1 (sck_oe == ($past(role) & $past(en)));
	endproperty
	a_role_oe: assert property (p_role_oe) else $error("clock drive not by role");

	property p_edge1;
		@(posedge aclk) disable iff (!aresetn)
		(st_reg == SPC_SHIFT && edge_eff && !trail) |=> $stable(sdo);
	endproperty
	a_edge1: assert property (p_edge1) else $error("output moved off trailing edge");

	property p_edge0;
		@(posedge aclk) disable iff (!aresetn)
		(st_reg == SPC_SHIFT && !edge_eff && !lead) |=> $stable(sdo);
	endproperty
	a_edge0: assert property (p_edge0) else $error("output moved off leading edge");

	property p_sel_gate;
		@(posedge aclk) disable iff (!aresetn)
		(!role && ssel_en && !framed && sel_n_s && st_reg == SPC_SHIFT) |=> $stable(cnt_reg);
	endproperty
	a_sel_gate: assert property (p_sel_gate) else $error("target shifted while deselected");

	property p_port_own;
		@(posedge aclk) disable iff (!aresetn)
		(!ssel_en && $stable(ssel_en)) |=> select_pin_port_owned;
	endproperty
	a_port_own: assert property (p_port_own) else $error("select pin not released");

	property p_framed;
		@(posedge aclk) disable iff (!aresetn)
		(st_reg == SPC_SHIFT && framed && !lead) |=> $stable(sdo);
	endproperty
	a_framed: assert property (p_framed) else $error("edge select used in framed mode");
endmodule
